// [core/pulse_density_modulator.sv]
// LFSR pulse density modulator with classic Wishbone register slave
`timescale 1ns/1ps

module pulse_density_modulator #(
  parameter int RESOLUTION = pdm_pkg::RESOLUTION_DEFAULT,
  parameter bit FIXED_SENSE = 1'b0,
  parameter pdm_pkg::sense_t FIXED_SENSE_A = pdm_pkg::SENSE_LE,
  parameter pdm_pkg::sense_t FIXED_SENSE_B = pdm_pkg::SENSE_LE
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic enable_in,
  input wire logic restart_in,
  input wire logic force_low_in,
  output logic density_out_a,
  output logic density_out_b,
  output logic serial_out,
  output logic sequence_wrap_pulse
);

  localparam int W = RESOLUTION;
  localparam logic [W-1:0] SEED_RESET = {W{1'b1}};
  localparam logic [W-1:0] TAPS_RESET = W'(pdm_pkg::default_taps(W));
  localparam logic [W-1:0] ALL_ONES = {W{1'b1}};
  localparam bit WRAP_OK = (W == 8) || (W == 16) || (W == 24) || (W == 32);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic enable_s;
  logic restart_s;
  logic force_s;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {force_low_in, restart_in, enable_in};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign enable_s = pin_sync_r[0];
  assign restart_s = pin_sync_r[1];
  assign force_s = pin_sync_r[2];

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  logic ack_r;
  logic [31:0] rd_data_r;
  logic req;
  logic wr_strobe;
  logic [31:0] wmask;

  logic run_r;
  pdm_pkg::sense_t sense_a_r;
  pdm_pkg::sense_t sense_b_r;
  logic [W-1:0] taps_r;
  logic [W-1:0] seed_r;
  logic [W-1:0] thr_a_r;
  logic [W-1:0] thr_b_r;
  logic [W-1:0] lfsr_r;
  pdm_pkg::sense_t sense_a;
  pdm_pkg::sense_t sense_b;

  assign req = wb_cyc_in && wb_stb_in;
  // Write lands on the edge where the master sees ack
  assign wr_strobe = req && wb_we_in && ack_r;

  generate
    for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wmask[8*b +: 8] = {8{wb_sel_in[b]}};
    end
  endgenerate

  function automatic logic [W-1:0] merge(input logic [W-1:0] old);
    logic [31:0] wide;
    wide = (32'(old) & ~wmask) | (wb_dat_in & wmask);
    return wide[W-1:0];
  endfunction

  // One wait state, ack dropped the cycle after
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Unmapped offsets read as zero and ignore writes
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_r <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      unique case (wb_adr_in)
        pdm_pkg::OFS_CTRL: begin
          rd_data_r <= 32'h0000_0000;
          rd_data_r[pdm_pkg::CTRL_RUN_BIT] <= run_r;
          rd_data_r[pdm_pkg::CTRL_SENSE_A_BIT] <= sense_a;
          rd_data_r[pdm_pkg::CTRL_SENSE_B_BIT] <= sense_b;
        end
        pdm_pkg::OFS_TAPS: rd_data_r <= 32'(taps_r);
        pdm_pkg::OFS_SEED: rd_data_r <= 32'(seed_r);
        pdm_pkg::OFS_THR_A: rd_data_r <= 32'(thr_a_r);
        pdm_pkg::OFS_THR_B: rd_data_r <= 32'(thr_b_r);
        pdm_pkg::OFS_VALUE: rd_data_r <= 32'(lfsr_r);
        default: rd_data_r <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_out = ack_r;
  assign wb_dat_out = rd_data_r;

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  // Fixed sense: no stop, the enable pin does the stopping
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      run_r <= pdm_pkg::CTRL_RUN_RESET;
    end else if (wr_strobe && wb_adr_in == pdm_pkg::OFS_CTRL && wb_sel_in[0]) begin
      if (FIXED_SENSE) begin
        run_r <= run_r | wb_dat_in[pdm_pkg::CTRL_RUN_BIT];
      end else begin
        run_r <= wb_dat_in[pdm_pkg::CTRL_RUN_BIT];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sense_a_r <= pdm_pkg::SENSE_A_RESET;
      sense_b_r <= pdm_pkg::SENSE_B_RESET;
    end else if (wr_strobe && wb_adr_in == pdm_pkg::OFS_CTRL && wb_sel_in[0]) begin
      sense_a_r <= pdm_pkg::sense_t'(wb_dat_in[pdm_pkg::CTRL_SENSE_A_BIT]);
      sense_b_r <= pdm_pkg::sense_t'(wb_dat_in[pdm_pkg::CTRL_SENSE_B_BIT]);
    end
  end

  // Sense flops are left unread when fixed, so synthesis drops them
  assign sense_a = FIXED_SENSE ? FIXED_SENSE_A : sense_a_r;
  assign sense_b = FIXED_SENSE ? FIXED_SENSE_B : sense_b_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence configuration

  // Taps above the width cannot be stored, the mask is only W bits
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      taps_r <= TAPS_RESET;
      seed_r <= SEED_RESET;
      thr_a_r <= W'(pdm_pkg::THR_RESET);
      thr_b_r <= W'(pdm_pkg::THR_RESET);
    end else if (wr_strobe) begin
      if (wb_adr_in == pdm_pkg::OFS_TAPS) begin
        taps_r <= merge(taps_r);
      end
      if (wb_adr_in == pdm_pkg::OFS_SEED) begin
        seed_r <= merge(seed_r);
      end
      if (wb_adr_in == pdm_pkg::OFS_THR_A) begin
        thr_a_r <= merge(thr_a_r);
      end
      if (wb_adr_in == pdm_pkg::OFS_THR_B) begin
        thr_b_r <= merge(thr_b_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Galois LFSR

  logic [W-1:0] lfsr_step;
  logic stepping;

  assign lfsr_step = (lfsr_r >> 1) ^ (lfsr_r[0] ? taps_r : '0);
  assign stepping = run_r && enable_s && !restart_s;

  // A zero seed would lock the register at zero forever
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lfsr_r <= SEED_RESET;
    end else if (run_r && restart_s) begin
      lfsr_r <= seed_r;
    end else if (stepping) begin
      lfsr_r <= lfsr_step;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic cmp_a;
  logic cmp_b;
  logic dens_a_r;
  logic dens_b_r;
  logic serial_r;
  logic wrap_r;

  // Threshold 0 under LE gives 0 %, all ones gives 100 %
  assign cmp_a = (sense_a == pdm_pkg::SENSE_LE) ? (lfsr_r <= thr_a_r)
    : (lfsr_r >= thr_a_r);
  assign cmp_b = (sense_b == pdm_pkg::SENSE_LE) ? (lfsr_r <= thr_b_r)
    : (lfsr_r >= thr_b_r);

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      dens_a_r <= 1'b0;
      dens_b_r <= 1'b0;
    end else if (force_s) begin
      dens_a_r <= 1'b0;
      dens_b_r <= 1'b0;
    end else if (run_r) begin
      dens_a_r <= cmp_a;
      dens_b_r <= cmp_b;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      serial_r <= 1'b0;
    end else if (run_r) begin
      serial_r <= lfsr_r[0];
    end
  end

  // Gated by stepping so a paused all-ones value gives one pulse only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      wrap_r <= 1'b0;
    end else begin
      wrap_r <= WRAP_OK && stepping && (lfsr_r == ALL_ONES);
    end
  end

  assign density_out_a = dens_a_r;
  assign density_out_b = dens_b_r;
  assign serial_out = serial_r;
  assign sequence_wrap_pulse = wrap_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  property p_step;
    stepping |=> lfsr_r == $past(lfsr_step);
  endproperty
  a_step: assert property (p_step) else $error("lfsr did not take Galois step");

  property p_restart;
    run_r && restart_s |=> lfsr_r == $past(seed_r);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not load seed");

  property p_hold;
    !run_r && !force_s |=> $stable(lfsr_r) && $stable(dens_a_r) && $stable(dens_b_r)
      && $stable(serial_r);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped block changed state");

  property p_force;
    force_s |=> !density_out_a && !density_out_b;
  endproperty
  a_force: assert property (p_force) else $error("force low not honoured");

  property p_cmp_a;
    run_r && !force_s && sense_a == pdm_pkg::SENSE_LE
      |=> density_out_a == ($past(lfsr_r) <= $past(thr_a_r));
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("density a wrong under le");

  property p_cmp_b;
    run_r && !force_s && sense_b == pdm_pkg::SENSE_GE
      |=> density_out_b == ($past(lfsr_r) >= $past(thr_b_r));
  endproperty
  a_cmp_b: assert property (p_cmp_b) else $error("density b wrong under ge");

  property p_cmp_a_ge;
    run_r && !force_s && sense_a == pdm_pkg::SENSE_GE
      |=> density_out_a == ($past(lfsr_r) >= $past(thr_a_r));
  endproperty
  a_cmp_a_ge: assert property (p_cmp_a_ge) else $error("density a wrong under ge");

  property p_cmp_b_le;
    run_r && !force_s && sense_b == pdm_pkg::SENSE_LE
      |=> density_out_b == ($past(lfsr_r) <= $past(thr_b_r));
  endproperty
  a_cmp_b_le: assert property (p_cmp_b_le) else $error("density b wrong under le");

  // Paused without restart: the sequence must not move
  property p_idle;
    !stepping && !(run_r && restart_s) |=> $stable(lfsr_r);
  endproperty
  a_idle: assert property (p_idle) else $error("lfsr moved while paused");

  property p_fixed_run;
    FIXED_SENSE && run_r |=> run_r;
  endproperty
  a_fixed_run: assert property (p_fixed_run) else $error("fixed build stopped by software");

  property p_serial;
    run_r |=> serial_out == $past(lfsr_r[0]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial bit mismatch");

  property p_wrap;
    sequence_wrap_pulse |-> $past(lfsr_r) == ALL_ONES ##1 !sequence_wrap_pulse;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap pulse wrong");

  property p_wrap_set;
    WRAP_OK && stepping && lfsr_r == ALL_ONES |=> sequence_wrap_pulse;
  endproperty
  a_wrap_set: assert property (p_wrap_set) else $error("wrap pulse missing");

  property p_restart_nowrap;
    run_r && restart_s |=> !sequence_wrap_pulse;
  endproperty
  a_restart_nowrap: assert property (p_restart_nowrap) else $error("wrap during restart");

  property p_ack;
    wb_ack_out |=> !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

  c_wrap: cover property (sequence_wrap_pulse);
  c_restart: cover property (run_r && restart_s ##1 stepping);
  c_force: cover property (density_out_a ##1 force_s ##2 !density_out_a);
  c_stop: cover property (run_r ##1 !run_r);
  c_ge: cover property (run_r && sense_a == pdm_pkg::SENSE_GE ##1 density_out_a);

endmodule

// [core/pdm_pkg.sv]
// Constants, register map and default tap table for the pulse density modulator
//
// Function
// - Pseudo-random sequence comes from a Galois-form LFSR with maximal-length taps.
// - LFSR width selectable 2 to 32 bits; period is 2^width minus 1.
// - Default maximal-length tap set supplied for every width.
// - Tap mask held as polynomial value; 8-bit default taps 8,6,5,4 equal b8.
// - Default seed is all ones at the chosen width.
// - LFSR steps every clock while started, enable high and restart low.
// - Restart high on a started block reloads the seed.
// - Force-low input drives both density outputs to zero while high.
// - Both density outputs compare the same LFSR value with own threshold.
// - Less-or-equal sense: output high while value at or below threshold.
// - Greater-or-equal sense: output high while value at or above threshold.
// - Each density output has its own selectable compare sense.
// - Density adjustable over the full range from 0 to 100 percent.
// - Serial output shows the LFSR least significant bit one clock later, updated only while started.
// - For 8/16/24/32 bits, wrap pulse lasts one clock, one clock after a stepped all-ones value.
// - Fixed-sense option removes sense control and the software stop.
// - Stepping starts at a rising clock edge after software starts it.
// - Software stop halts the LFSR and holds density and serial outputs unless force-low is high.
package pdm_pkg;

  typedef enum logic {
    SENSE_LE,
    SENSE_GE
  } sense_t;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TAPS = 8'h04;
  localparam logic [7:0] OFS_SEED = 8'h08;
  localparam logic [7:0] OFS_THR_A = 8'h0c;
  localparam logic [7:0] OFS_THR_B = 8'h10;
  localparam logic [7:0] OFS_VALUE = 8'h14;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SENSE_A_BIT = 1;
  localparam int CTRL_SENSE_B_BIT = 2;

  localparam logic CTRL_RUN_RESET = 1'h0;
  localparam sense_t SENSE_A_RESET = SENSE_LE;
  localparam sense_t SENSE_B_RESET = SENSE_LE;
  localparam logic [31:0] THR_RESET = 32'h0000_0001;
  localparam int RESOLUTION_DEFAULT = 8;

  // Galois masks: tap n sets bit n-1
  function automatic logic [31:0] default_taps(input int width);
    logic [31:0] m;
    m = 32'h0000_0000;
    case (width)
      2: m = 32'h0000_0003;
      3: m = 32'h0000_0006;
      4: m = 32'h0000_000c;
      5: m = 32'h0000_001e;
      6: m = 32'h0000_0036;
      7: m = 32'h0000_0078;
      8: m = 32'h0000_00b8;
      9: m = 32'h0000_01b0;
      10: m = 32'h0000_0360;
      11: m = 32'h0000_0740;
      12: m = 32'h0000_0ca0;
      13: m = 32'h0000_1b00;
      14: m = 32'h0000_3500;
      15: m = 32'h0000_7400;
      16: m = 32'h0000_b400;
      17: m = 32'h0001_e000;
      18: m = 32'h0003_9000;
      19: m = 32'h0007_2000;
      20: m = 32'h000c_a000;
      21: m = 32'h001c_8000;
      22: m = 32'h0027_0000;
      23: m = 32'h006a_0000;
      24: m = 32'h00d8_0000;
      25: m = 32'h01e0_0000;
      26: m = 32'h0388_0000;
      27: m = 32'h0720_0000;
      28: m = 32'h0ca0_0000;
      29: m = 32'h1d00_0000;
      30: m = 32'h3280_0000;
      31: m = 32'h7800_0000;
      32: m = 32'ha300_0000;
      default: m = 32'h0000_0000;
    endcase
    return m;
  endfunction

endpackage

// [sim/density_sink_model.sv]
// Light-sink model that counts output activity inside a sampling window
`timescale 1ns/1ps

module density_sink_model (
  input wire logic clk_in,
  input wire logic clear_in,
  input wire logic window_in,
  input wire logic density_a_in,
  input wire logic density_b_in,
  input wire logic serial_in,
  input wire logic wrap_in,
  output logic [31:0] count_a_out,
  output logic [31:0] count_b_out,
  output logic [31:0] ones_out,
  output logic [31:0] wraps_out
);
  // Window keeps start and stop edge effects out of the counts
  always_ff @(posedge clk_in) begin
    if (clear_in) begin
      count_a_out <= 32'h0;
      count_b_out <= 32'h0;
      ones_out <= 32'h0;
      wraps_out <= 32'h0;
    end else if (window_in) begin
      count_a_out <= count_a_out + 32'(density_a_in);
      count_b_out <= count_b_out + 32'(density_b_in);
      ones_out <= ones_out + 32'(serial_in);
      wraps_out <= wraps_out + 32'(wrap_in);
    end
  end
endmodule

// [sim/lfsr_pulse_density_modulator_tb.sv]
// Self-checking bench for the LFSR pulse density modulator
`timescale 1ns/1ps

module lfsr_pulse_density_modulator_tb;
  localparam int MAXV = 255;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic enable = 1'b0, restart = 1'b0, force_low = 1'b0, clear = 1'b0, window = 1'b0;
  logic [31:0] wb_dat_out, count_a, count_b, ones, wraps;
  logic [31:0] fixed_dat;
  logic wb_ack_out, density_out_a, density_out_b, serial_out, sequence_wrap_pulse;
  int errors = 0;
  int samples_checked = 0;

  // 15 ns period keeps the clock under the 67 MHz ceiling
  always #7.5 clk_in = ~clk_in;

  pulse_density_modulator #(.RESOLUTION(8)) pulse_density_modulator_inst (
    .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .enable_in(enable),
    .restart_in(restart), .force_low_in(force_low), .density_out_a(density_out_a),
    .density_out_b(density_out_b), .serial_out(serial_out),
    .sequence_wrap_pulse(sequence_wrap_pulse)
  );

  // Build-time sense copy on the same bus and pins; only its read data is judged
  pulse_density_modulator #(
    .RESOLUTION(8), .FIXED_SENSE(1'b1), .FIXED_SENSE_A(pdm_pkg::SENSE_GE),
    .FIXED_SENSE_B(pdm_pkg::SENSE_LE)
  ) pulse_density_modulator_fixed_inst (
    .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(fixed_dat), .wb_ack_out(), .enable_in(enable),
    .restart_in(restart), .force_low_in(force_low), .density_out_a(),
    .density_out_b(), .serial_out(), .sequence_wrap_pulse()
  );

  density_sink_model density_sink_model_inst (
    .clk_in(clk_in), .clear_in(clear), .window_in(window), .density_a_in(density_out_a),
    .density_b_in(density_out_b), .serial_in(serial_out), .wrap_in(sequence_wrap_pulse),
    .count_a_out(count_a), .count_b_out(count_b), .ones_out(ones), .wraps_out(wraps)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits on ack with its own bound; no fixed latency assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    q = wb_dat_out;
    if (n >= 50) check(1'b0, 1'b1);
    cyc <= 1'b0; stb <= 1'b0;
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] v, input logic [31:0] m);
    return (v >> 1) ^ (v[0] ? m : 32'h0);
  endfunction

  // Any 255 running cycles visit every nonzero value once
  function automatic int dens(input pdm_pkg::sense_t s, input int t);
    return (s == pdm_pkg::SENSE_GE) ? MAXV + 1 - t : t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs_reset;
    logic [31:0] q;
    check({density_out_a, density_out_b, serial_out, sequence_wrap_pulse}, 32'h0);
    wb(1'b0, pdm_pkg::OFS_CTRL, 32'h0, q); check(q, 32'h0);
    wb(1'b0, pdm_pkg::OFS_TAPS, 32'h0, q); check(q, 32'h0000_00b8);
    wb(1'b0, pdm_pkg::OFS_SEED, 32'h0, q); check(q, 32'h0000_00ff);
    wb(1'b0, pdm_pkg::OFS_THR_A, 32'h0, q); check(q, 32'h1);
    wb(1'b0, pdm_pkg::OFS_THR_B, 32'h0, q); check(q, 32'h1);
    wb(1'b1, pdm_pkg::OFS_VALUE, 32'h12, q);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q); check(q, 32'h0000_00ff);
    wb(1'b0, 8'h18, 32'h0, q); check(q, 32'h0);
  endtask

  task automatic t_step(input logic [31:0] mask, input logic [31:0] seed, input int n);
    logic [31:0] q, v;
    wb(1'b1, pdm_pkg::OFS_TAPS, mask, q);
    wb(1'b1, pdm_pkg::OFS_SEED, seed, q);
    wb(1'b1, pdm_pkg::OFS_CTRL, 32'h1, q);
    @(posedge clk_in); restart <= 1'b1;
    repeat (4) @(posedge clk_in); restart <= 1'b0;
    repeat (6) @(posedge clk_in);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q); check(q, seed);
    // Sync delay is equal on both enable edges, so n sampled highs give n steps
    @(posedge clk_in); enable <= 1'b1;
    repeat (n) @(posedge clk_in); enable <= 1'b0;
    repeat (6) @(posedge clk_in);
    v = seed;
    for (int i = 0; i < n; i++) v = lfsr_next(v, mask);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q); check(q, v);
    check(serial_out, v[0]);
    wb(1'b1, pdm_pkg::OFS_CTRL, 32'h0, q);
    @(posedge clk_in); enable <= 1'b1; restart <= 1'b1;
    repeat (10) @(posedge clk_in); enable <= 1'b0; restart <= 1'b0;
    repeat (6) @(posedge clk_in);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q); check(q, v);
    check(serial_out, v[0]);
  endtask

  task automatic t_density(input pdm_pkg::sense_t sa, input pdm_pkg::sense_t sb,
                           input int ta, input int tb, input logic kill);
    logic [31:0] q;
    wb(1'b1, pdm_pkg::OFS_THR_A, 32'(ta), q);
    wb(1'b1, pdm_pkg::OFS_THR_B, 32'(tb), q);
    wb(1'b1, pdm_pkg::OFS_CTRL, 32'h1 | (32'(sa) << pdm_pkg::CTRL_SENSE_A_BIT) |
       (32'(sb) << pdm_pkg::CTRL_SENSE_B_BIT), q);
    @(posedge clk_in); enable <= 1'b1; force_low <= kill; clear <= 1'b1;
    repeat (8) @(posedge clk_in); clear <= 1'b0; window <= 1'b1;
    repeat (MAXV) @(posedge clk_in); window <= 1'b0;
    @(posedge clk_in);
    check(count_a, kill ? 32'h0 : 32'(dens(sa, ta)));
    check(count_b, kill ? 32'h0 : 32'(dens(sb, tb)));
    check(ones, 32'h80);
    check(wraps, 32'h1);
    enable <= 1'b0; force_low <= 1'b0;
  endtask

  // Fixed copy: run sticks, sense bits ignored, only the enable pin halts it
  task automatic t_fixed;
    logic [31:0] q, v;
    wb(1'b1, pdm_pkg::OFS_CTRL, 32'h6, q);
    wb(1'b0, pdm_pkg::OFS_CTRL, 32'h0, q);
    check(q, 32'h6);
    check(fixed_dat, 32'h3);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q);
    v = fixed_dat;
    repeat (20) @(posedge clk_in);
    wb(1'b0, pdm_pkg::OFS_VALUE, 32'h0, q);
    check(fixed_dat, v);
  endtask

  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_regs_reset;
    t_step(32'h0000_008e, 32'h0000_005a, 37);
    // Full period with default taps must land back on the seed
    t_step(32'h0000_00b8, 32'h0000_00ff, MAXV);
    t_density(pdm_pkg::SENSE_LE, pdm_pkg::SENSE_GE, 128, 64, 1'b0);
    t_density(pdm_pkg::SENSE_GE, pdm_pkg::SENSE_LE, MAXV, MAXV, 1'b0);
    t_density(pdm_pkg::SENSE_LE, pdm_pkg::SENSE_GE, 1, 1, 1'b0);
    t_density(pdm_pkg::SENSE_GE, pdm_pkg::SENSE_GE, 128, 128, 1'b1);
    t_density(pdm_pkg::SENSE_GE, pdm_pkg::SENSE_GE, 128, 128, 1'b0);
    t_fixed;
    final_report;
  end

  // Whole run needs about 1840 cycles; this allows over ten times that
  initial begin
    #400_000;
    errors++;
    $display("BAD at %0t: watchdog expired", $time);
    final_report;
  end
endmodule
